// >>> src/eep_pkg.sv
// Shared constants and types for the serial EEPROM sequencer ends.
// Operation
// - Byte write: address, data, each acknowledged low.
// - Stop ends a write and starts programming.
// - While programming, ignore bus and never acknowledge.
// - Page write loads up to sixty-four bytes.
// - Acknowledge each byte, increment in-page address only.
// - Page bits fixed; offset wraps within page.
// - Wrap on page size, not sixteen bytes.
// - ID page write: type 1011, lock bit zero.
// - Locked ID page: no acknowledge, unchanged.
// - Polling: acknowledge only after programming ends.
// - Read selected by read/write bit one.
// - Address counter holds last location plus one.
// - Read past last byte wraps to zero.
// - Current read: one byte, no ack, stop.
// - Random read: dummy write, repeated start, read.
// - Ack continues sequential read; nack plus stop ends.
// - ID page read, random format, stay in page.
// - Lock: byte write, lock bit one, bit1 set.
// - Program time runs from stop to write end.
// - Chip-select bits must match pins, else standby.
// - Write-protect pin high blocks array writes.
// - Fourteen-bit address, 256 pages of 64.
// - Acknowledge low during the ninth clock.
package eep_pkg;
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 3000;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int PCNT_W = 20;
  localparam int SCL_KHZ = 1000;
  localparam int QTR_CYC = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
  localparam logic [2:0] DEV_TYPE_TOP = 3'h5;
  localparam int ID_TYPE_BIT = 4;
  localparam int ID_LOCK_SEL_POS = 2;
  localparam int LOCK_DATA_POS = 1;
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int MEM_BYTES = 16384;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_NACK = 4;
  localparam int TX_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int RX_LSB = 8;
  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_DEVADR = 6'b000010,
    D_ADRHI = 6'b000100,
    D_ADRLO = 6'b001000,
    D_WDATA = 6'b010000,
    D_RDATA = 6'b100000
  } eep_dstate_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_START = 4'b0010,
    H_BIT = 4'b0100,
    H_STOP = 4'b1000
  } eep_hstate_t;
endpackage : eep_pkg

// >>> src/eep_if.sv
// Two-wire link between the controller end and the EEPROM end.
`timescale 1ns/1ps
interface eep_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // Open-drain wired-AND with the external pull-up.
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : eep_if

// >>> src/eep_cond.sv
// Bus edge and start/stop condition detector.
`timescale 1ns/1ps
module eep_cond (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o,
  output logic sda_o
);
  logic scl_q, sda_q, scl_p, sda_p;

  // Sample the lines and keep one cycle of history; idle bus is high.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // Data moving while the clock is high marks a start or a stop.
  assign scl_rise_o = scl_q && !scl_p;
  assign scl_fall_o = !scl_q && scl_p;
  assign start_o = scl_q && scl_p && sda_p && !sda_q;
  assign stop_o = scl_q && scl_p && !sda_p && sda_q;
  assign sda_o = sda_q;
endmodule : eep_cond

// >>> src/eep_dev.sv
// EEPROM end: two-wire slave sequencer with array, ID page and lock.
`timescale 1ns/1ps
module eep_dev #(
  parameter int PROG_CYCLES = eep_pkg::PROG_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic chip_select_bit2_i,
  input wire logic chip_select_bit1_i,
  input wire logic chip_select_bit0_i,
  input wire logic wp_i,
  output logic busy_o,
  output logic id_locked_o,
  eep_if.dev bus
);
  localparam logic [eep_pkg::PCNT_W-1:0] PROG_LAST =
    eep_pkg::PCNT_W'(PROG_CYCLES - 1);

  logic scl_rise, scl_fall, start_p, stop_p, sda_s;
  eep_pkg::eep_dstate_t st_r;
  logic [3:0] cnt_r;
  logic ack_ph_r;
  logic drv_r;
  logic is_id_r;
  logic lock_sel_r;
  logic wr_any_r;
  logic lock_pend_r;
  logic [7:0] sr_r;
  logic [7:0] hi_r;
  logic [eep_pkg::ADDR_W-1:0] addr_r;
  logic [eep_pkg::PAGE_W-1:0] id_off_r;
  logic [eep_pkg::PAGE_W-1:0] woff;
  logic [7:0] wbuf [0:eep_pkg::PAGE_BYTES-1];
  logic [eep_pkg::PAGE_BYTES-1:0] bvalid_r;
  logic busy_r, locked_r, prog_go, prog_done;
  logic [eep_pkg::PCNT_W-1:0] pcnt_r;
  logic [7:0] mem [0:eep_pkg::MEM_BYTES-1];
  logic [7:0] idmem [0:eep_pkg::PAGE_BYTES-1];
  logic [2:0] cs;
  logic dev_hit;
  logic [7:0] rd_byte;

  eep_cond u_cond (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_p),
    .stop_o(stop_p),
    .sda_o(sda_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and outputs.

  // Address byte must carry the family code, our select pins, and no busy.
  assign cs = {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};
  assign dev_hit = (sr_r[7:5] == eep_pkg::DEV_TYPE_TOP)
                   && (sr_r[3:1] == cs)
                   && !busy_r;
  // The in-page offset of the current write target.
  assign woff = is_id_r ? id_off_r : addr_r[eep_pkg::PAGE_W-1:0];
  assign rd_byte = is_id_r ? idmem[id_off_r] : mem[addr_r];
  assign prog_go = stop_p && wr_any_r && !busy_r;
  assign prog_done = busy_r && (pcnt_r == PROG_LAST);
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = drv_r;
  assign busy_o = busy_r;
  assign id_locked_o = locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer.

  // Shifts bytes in and out, drives acknowledges and loads the page buffer.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= eep_pkg::D_IDLE;
      cnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      drv_r <= 1'b0;
      is_id_r <= 1'b0;
      lock_sel_r <= 1'b0;
      wr_any_r <= 1'b0;
      lock_pend_r <= 1'b0;
      sr_r <= 8'h00;
      hi_r <= 8'h00;
      addr_r <= '0;
      id_off_r <= '0;
      bvalid_r <= '0;
    end else if (start_p) begin
      st_r <= eep_pkg::D_DEVADR;
      cnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      drv_r <= 1'b0;
      wr_any_r <= 1'b0;
    end else if (stop_p) begin
      st_r <= eep_pkg::D_IDLE;
      ack_ph_r <= 1'b0;
      drv_r <= 1'b0;
      wr_any_r <= 1'b0;
    end else if (ack_ph_r && scl_fall) begin
      // End of the ninth clock: release, or start the next read byte.
      ack_ph_r <= 1'b0;
      cnt_r <= 4'h0;
      if (st_r == eep_pkg::D_RDATA) begin
        drv_r <= ~rd_byte[7];
        sr_r <= {rd_byte[6:0], 1'b0};
        if (is_id_r) begin
          id_off_r <= id_off_r + 1'b1;
        end else begin
          addr_r <= addr_r + 1'b1;
        end
      end else begin
        drv_r <= 1'b0;
      end
    end else if (ack_ph_r && scl_rise) begin
      // Controller answer after a read byte; high means no more data.
      if (st_r == eep_pkg::D_RDATA && sda_s) begin
        st_r <= eep_pkg::D_IDLE;
      end
    end else begin
      case (st_r)
        eep_pkg::D_IDLE: begin
          drv_r <= 1'b0;
        end
        eep_pkg::D_RDATA: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (scl_fall && cnt_r == eep_pkg::LAST_BIT) begin
            drv_r <= 1'b0;
            ack_ph_r <= 1'b1;
          end else if (scl_fall) begin
            drv_r <= ~sr_r[7];
            sr_r <= {sr_r[6:0], 1'b0};
          end
        end
        default: begin
          if (scl_rise && cnt_r != eep_pkg::LAST_BIT) begin
            sr_r <= {sr_r[6:0], sda_s};
            cnt_r <= cnt_r + 1'b1;
          end else if (scl_fall && cnt_r == eep_pkg::LAST_BIT) begin
            // Eighth bit done: decide the acknowledge for the ninth clock.
            ack_ph_r <= 1'b1;
            drv_r <= 1'b1;
            case (st_r)
              eep_pkg::D_DEVADR: begin
                if (!dev_hit) begin
                  ack_ph_r <= 1'b0;
                  drv_r <= 1'b0;
                  st_r <= eep_pkg::D_IDLE;
                end else begin
                  is_id_r <= sr_r[eep_pkg::ID_TYPE_BIT];
                  if (sr_r[0]) begin
                    st_r <= eep_pkg::D_RDATA;
                  end else begin
                    st_r <= eep_pkg::D_ADRHI;
                    bvalid_r <= '0;
                    lock_pend_r <= 1'b0;
                  end
                end
              end
              eep_pkg::D_ADRHI: begin
                hi_r <= sr_r;
                st_r <= eep_pkg::D_ADRLO;
              end
              eep_pkg::D_ADRLO: begin
                lock_sel_r <= hi_r[eep_pkg::ID_LOCK_SEL_POS];
                if (is_id_r) begin
                  id_off_r <= sr_r[eep_pkg::PAGE_W-1:0];
                end else begin
                  addr_r <= {hi_r[5:0], sr_r};
                end
                st_r <= eep_pkg::D_WDATA;
              end
              eep_pkg::D_WDATA: begin
                if (is_id_r && lock_sel_r) begin
                  if (sr_r[eep_pkg::LOCK_DATA_POS]) begin
                    lock_pend_r <= 1'b1;
                    wr_any_r <= 1'b1;
                  end
                end else if (is_id_r && locked_r) begin
                  ack_ph_r <= 1'b0;
                  drv_r <= 1'b0;
                  st_r <= eep_pkg::D_IDLE;
                end else begin
                  wbuf[woff] <= sr_r;
                  bvalid_r[woff] <= 1'b1;
                  if (is_id_r || !wp_i) begin
                    wr_any_r <= 1'b1;
                  end
                  // Only the in-page offset moves; page bits stay put.
                  if (is_id_r) begin
                    id_off_r <= id_off_r + 1'b1;
                  end else begin
                    addr_r[eep_pkg::PAGE_W-1:0] <= woff + 1'b1;
                  end
                end
              end
              default: begin
                st_r <= eep_pkg::D_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed programming cycle.

  // Runs from the ending stop until the write completes; sets the lock.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_r <= 1'b0;
      pcnt_r <= '0;
      locked_r <= 1'b0;
    end else if (busy_r) begin
      if (prog_done) begin
        busy_r <= 1'b0;
        if (lock_pend_r) begin
          locked_r <= 1'b1;
        end
      end else begin
        pcnt_r <= pcnt_r + 1'b1;
      end
    end else if (prog_go) begin
      busy_r <= 1'b1;
      pcnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  // Committing at the end keeps old data readable until programming is done.
  always_ff @(posedge clk_i) begin
    if (prog_done) begin
      for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
        if (bvalid_r[i] && is_id_r && !locked_r) begin
          idmem[i] <= wbuf[i];
        end else if (bvalid_r[i] && !is_id_r) begin
          mem[{addr_r[13:6], 6'(i)}] <= wbuf[i];
        end
      end
    end
  end
endmodule : eep_dev

// >>> src/eep_host.sv
// Controller end: AHB-Lite driven two-wire byte engine.
`timescale 1ns/1ps
module eep_host (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  eep_if.host bus
);
  eep_pkg::eep_hstate_t st_r;
  logic ap_v_r, ap_wr_r;
  logic [7:0] ap_adr_r;
  logic [31:0] rdata_r;
  logic [4:0] qcnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] tx_r;
  logic [7:0] rx_r;
  logic nack_r, rd_r, scl_r, drv_r;
  logic p_start_r, p_byte_r, p_stop_r;
  logic busy, tick, wr_go;

  // True when a word address selects the given register.
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, always OKAY.

  assign busy = p_start_r || p_byte_r || p_stop_r || (st_r != eep_pkg::H_IDLE);
  assign wr_go = ap_v_r && ap_wr_r && reg_hit(ap_adr_r, eep_pkg::CMD_OFS);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_r;
  assign bus.scl = scl_r;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = drv_r;

  // Address phase capture and read data for the following data phase.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ap_v_r <= 1'b0;
      ap_wr_r <= 1'b0;
      ap_adr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else if (hready_i) begin
      ap_v_r <= hsel_i && htrans_i[1];
      ap_wr_r <= hwrite_i;
      ap_adr_r <= haddr_i[7:0];
      rdata_r <= 32'h0000_0000;
      if (hsel_i && htrans_i[1] && !hwrite_i &&
          reg_hit(haddr_i[7:0], eep_pkg::STAT_OFS)) begin
        rdata_r[eep_pkg::ST_BUSY] <= busy;
        rdata_r[eep_pkg::ST_NACK] <= nack_r;
        rdata_r[eep_pkg::RX_LSB +: 8] <= rx_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit engine: four quarter periods per clock bit.

  assign tick = (qcnt_r == eep_pkg::QTR_LAST);

  // Runs queued start, byte and stop steps in that order.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= eep_pkg::H_IDLE;
      qcnt_r <= 5'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 9'h1FF;
      rx_r <= 8'h00;
      nack_r <= 1'b0;
      rd_r <= 1'b0;
      scl_r <= 1'b1;
      drv_r <= 1'b0;
      p_start_r <= 1'b0;
      p_byte_r <= 1'b0;
      p_stop_r <= 1'b0;
    end else if (st_r == eep_pkg::H_IDLE) begin
      qcnt_r <= 5'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      if (wr_go && !busy) begin
        p_start_r <= hwdata_i[eep_pkg::CMD_START];
        p_byte_r <= hwdata_i[eep_pkg::CMD_WRITE] | hwdata_i[eep_pkg::CMD_READ];
        p_stop_r <= hwdata_i[eep_pkg::CMD_STOP];
        rd_r <= hwdata_i[eep_pkg::CMD_READ];
        if (hwdata_i[eep_pkg::CMD_READ]) begin
          tx_r <= {8'hFF, hwdata_i[eep_pkg::CMD_NACK]};
        end else begin
          tx_r <= {hwdata_i[eep_pkg::TX_LSB +: 8], 1'b1};
        end
      end else if (p_start_r) begin
        p_start_r <= 1'b0;
        drv_r <= 1'b0;
        st_r <= eep_pkg::H_START;
      end else if (p_byte_r) begin
        p_byte_r <= 1'b0;
        drv_r <= ~tx_r[8];
        st_r <= eep_pkg::H_BIT;
      end else if (p_stop_r) begin
        p_stop_r <= 1'b0;
        drv_r <= 1'b1;
        st_r <= eep_pkg::H_STOP;
      end
    end else begin
      qcnt_r <= tick ? 5'h00 : qcnt_r + 1'b1;
      if (tick) begin
        ph_r <= ph_r + 1'b1;
        case (ph_r)
          2'h0: scl_r <= 1'b1;
          2'h1: begin
            if (st_r == eep_pkg::H_START) begin
              drv_r <= 1'b1;
            end else if (st_r == eep_pkg::H_STOP) begin
              drv_r <= 1'b0;
            end else if (bit_r == eep_pkg::LAST_BIT) begin
              if (!rd_r) begin
                nack_r <= bus.sda;
              end
            end else begin
              rx_r <= {rx_r[6:0], bus.sda};
            end
          end
          2'h2: scl_r <= (st_r == eep_pkg::H_STOP);
          default: begin
            if (st_r == eep_pkg::H_BIT && bit_r != eep_pkg::LAST_BIT) begin
              bit_r <= bit_r + 1'b1;
              drv_r <= ~tx_r[7];
              tx_r <= {tx_r[7:0], 1'b1};
            end else begin
              st_r <= eep_pkg::H_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : eep_host

// >>> dv/eep_checker.sv
// Link-level assertions for the joined controller and EEPROM ends.
`timescale 1ns/1ps
module eep_checker #(
  parameter int PROG_CYCLES = eep_pkg::PROG_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic busy_o
);
  logic [eep_pkg::PCNT_W-1:0] busy_cnt_r;

  ////////////////////////////////////////
  // Counts the cycles of the running programming period.
  always_ff @(posedge clk_i) begin
    if (srst_i || !busy_o) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  dev_oe_stable_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed sda while scl high");
  ack_hold_a: assert property (
    $rose(scl) && dev_sda_oe |-> dev_sda_oe[*8])
    else $error("device released sda during scl high");
  busy_quiet_a: assert property (
    busy_o && $past(busy_o) |-> !dev_sda_oe)
    else $error("device drove sda while programming");
  host_free_a: assert property (
    $rose(scl) && dev_sda_oe |-> !host_sda_oe)
    else $error("device drove sda while controller owns it");
  prog_start_a: assert property ($rose(busy_o) |-> scl && sda)
    else $error("programming began outside a stop");
  // The period lasts exactly the configured count of cycles.
  prog_len_a: assert property (
    busy_o |-> int'(busy_cnt_r) < PROG_CYCLES)
    else $error("programming period too long");
  prog_full_a: assert property (
    $fell(busy_o) |-> int'(busy_cnt_r) == PROG_CYCLES)
    else $error("programming period too short");
  od_drive_a: assert property (
    dev_sda_oe |-> !dev_sda_o && !sda && !host_sda_o)
    else $error("open-drain low not seen on sda");

  // Main scenarios: a programming cycle, a device answer, a refused poll.
  cover property ($rose(busy_o));
  cover property ($rose(scl) && dev_sda_oe);
  cover property ($rose(scl) && busy_o);
endmodule : eep_checker

// >>> dv/tb.sv
// Self-checking bench joining the controller end to the EEPROM end.
`timescale 1ns/1ps
module tb;
  localparam int PROG = 2000;
  localparam logic [4:0] SW = 5'h03;
  localparam logic [4:0] WR = 5'h02;
  localparam logic [4:0] WP = 5'h0A;
  localparam logic [4:0] SWP = 5'h0B;
  localparam logic [4:0] RD = 5'h04;
  localparam logic [4:0] RNP = 5'h1C;
  typedef struct packed {
    logic [4:0] f;
    logic [7:0] tx;
    logic [1:0] k;
    logic [7:0] e;
  } eep_row_t;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic wp = 1'b0;
  logic busy;
  logic locked;
  logic [31:0] last_st;
  logic [31:0] q;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  // Link script: function, byte sent, check kind, expected byte.
  eep_row_t rows [35] = '{
    '{SW, 8'hAA, 2'd0, 8'h00}, '{WR, 8'h00, 2'd0, 8'h00},
    '{WR, 8'h3F, 2'd0, 8'h00}, '{WR, 8'h11, 2'd0, 8'h00},
    '{WR, 8'h22, 2'd0, 8'h00}, '{WR, 8'h33, 2'd0, 8'h00},
    '{WP, 8'h44, 2'd0, 8'h00},
    '{SW, 8'hAA, 2'd0, 8'h00}, '{WR, 8'h00, 2'd0, 8'h00},
    '{WR, 8'h3F, 2'd0, 8'h00}, '{SW, 8'hAB, 2'd0, 8'h00},
    '{RNP, 8'h00, 2'd2, 8'h11},
    '{SW, 8'hAA, 2'd0, 8'h00}, '{WR, 8'hC0, 2'd0, 8'h00},
    '{WR, 8'h00, 2'd0, 8'h00}, '{SW, 8'hAB, 2'd0, 8'h00},
    '{RNP, 8'h00, 2'd2, 8'h22},
    '{SW, 8'hAB, 2'd0, 8'h00}, '{RD, 8'h00, 2'd2, 8'h33},
    '{RNP, 8'h00, 2'd2, 8'h44},
    '{SWP, 8'hA0, 2'd1, 8'h00}, '{SWP, 8'hEA, 2'd1, 8'h00},
    '{SW, 8'hBA, 2'd0, 8'h00}, '{WR, 8'h00, 2'd0, 8'h00},
    '{WR, 8'h05, 2'd0, 8'h00}, '{WP, 8'h77, 2'd0, 8'h00},
    '{SW, 8'hBA, 2'd0, 8'h00}, '{WR, 8'h00, 2'd0, 8'h00},
    '{WR, 8'h05, 2'd0, 8'h00}, '{SW, 8'hBB, 2'd0, 8'h00},
    '{RNP, 8'h00, 2'd2, 8'h77},
    '{SW, 8'hBA, 2'd0, 8'h00}, '{WR, 8'h04, 2'd0, 8'h00},
    '{WR, 8'h00, 2'd0, 8'h00}, '{WP, 8'h02, 2'd0, 8'h00}};

  eep_if bus_if ();

  ////////////////////////////////////////
  // Both ends share one link; select pins are strapped to 101.
  eep_host eep_host_i (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .bus(bus_if));
  eep_dev #(.PROG_CYCLES(PROG)) eep_dev_i (.clk_i(clk_i), .srst_i(srst_i),
    .chip_select_bit2_i(1'b1), .chip_select_bit1_i(1'b0),
    .chip_select_bit0_i(1'b1), .wp_i(wp), .busy_o(busy),
    .id_locked_o(locked), .bus(bus_if));
  eep_checker #(.PROG_CYCLES(PROG)) eep_checker_i (.clk_i(clk_i),
    .srst_i(srst_i), .scl(bus_if.scl), .host_sda_o(bus_if.host_sda_o),
    .host_sda_oe(bus_if.host_sda_oe), .dev_sda_o(bus_if.dev_sda_o),
    .dev_sda_oe(bus_if.dev_sda_oe), .sda(bus_if.sda), .busy_o(busy));

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // Counts one comparison and reports it when it misses.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  // Waits for the next edge with ready high; a hang ends the run.
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clk_i);
    while (hready !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 100) begin
      chk(32'h0, 32'h1, "ready timeout");
      close_out();
    end
  endtask : wait_rdy

  // One single-word transfer: address phase, then data phase.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask : ahb

  // Runs one link step and polls status until the engine is free.
  task automatic op(input logic [4:0] f, input logic [7:0] tx,
                    input logic [1:0] k, input logic [7:0] e);
    int c;
    ahb(1'b1, 8'h00, {16'h0000, tx, 3'h0, f}, last_st);
    c = 0;
    last_st = 32'h00000001;
    while (last_st[0] !== 1'b0 && c < 3000) begin
      ahb(1'b0, 8'h04, 32'h0, last_st);
      c++;
    end
    if (c >= 3000) begin
      chk(32'h0, 32'h1, "link timeout");
      close_out();
    end
    if (k < 2'd2) chk({31'h0, last_st[1]}, {31'h0, k[0]}, "ack mismatch");
    if (k == 2'd2) chk({24'h0, last_st[15:8]}, {24'h0, e}, "read mismatch");
  endtask : op

  // Random read of one byte and comparison with the expected value.
  task automatic rdchk(input logic [7:0] d, input logic [7:0] hi,
                       input logic [7:0] lo, input logic [7:0] e);
    op(SW, d, 2'd0, 8'h00);
    op(WR, hi, 2'd0, 8'h00);
    op(WR, lo, 2'd0, 8'h00);
    op(SW, d | 8'h01, 2'd0, 8'h00);
    op(RNP, 8'h00, 2'd2, e);
  endtask : rdchk

  // Waits out a programming cycle under a bounded count.
  task automatic idle;
    int c;
    c = 0;
    repeat (4) @(posedge clk_i);
    while (busy !== 1'b0 && c < PROG + 100) begin
      @(posedge clk_i);
      c++;
    end
    chk({31'h0, busy}, 32'h0, "programming never ended");
  endtask : idle

  ////////////////////////////////////////
  // Main sequence: reset, script rows, then the awkward cases.
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk({29'h0, bus_if.scl, bus_if.host_sda_oe, bus_if.dev_sda_oe},
        32'h4, "link not idle after reset");
    chk({30'h0, busy, locked}, 32'h0, "flags set after reset");
    for (int i = 0; i < 35; i++) begin
      op(rows[i].f, rows[i].tx, rows[i].k, rows[i].e);
      if (rows[i].f[3]) idle();
    end
    chk({31'h0, locked}, 32'h1, "page not locked");
    op(SW, 8'hBA, 2'd0, 8'h00);
    op(WR, 8'h00, 2'd0, 8'h00);
    op(WR, 8'h05, 2'd0, 8'h00);
    op(WR, 8'h99, 2'd1, 8'h00);
    op(5'h08, 8'h00, 2'd3, 8'h00);
    rdchk(8'hBA, 8'h00, 8'h05, 8'h77);
    // The last array byte is written so that a read can wrap past it.
    op(SW, 8'hAA, 2'd0, 8'h00);
    op(WR, 8'h3F, 2'd0, 8'h00);
    op(WR, 8'hFF, 2'd0, 8'h00);
    op(WP, 8'h5A, 2'd0, 8'h00);
    chk({31'h0, busy}, 32'h1, "programming not started");
    op(SWP, 8'hAA, 2'd1, 8'h00);
    n = 0;
    while (last_st[1] !== 1'b0 && n < 10) begin
      op(SWP, 8'hAA, 2'd3, 8'h00);
      n++;
    end
    chk({31'h0, last_st[1]}, 32'h0, "poll never answered");
    chk({31'h0, busy}, 32'h0, "busy after answered poll");
    rdchk(8'hAA, 8'h3F, 8'hFF, 8'h5A);
    wp <= 1'b1;
    op(SW, 8'hAA, 2'd0, 8'h00);
    op(WR, 8'h3F, 2'd0, 8'h00);
    op(WR, 8'hFF, 2'd0, 8'h00);
    op(WP, 8'hA5, 2'd0, 8'h00);
    repeat (4) @(posedge clk_i);
    chk({31'h0, busy}, 32'h0, "protected write programmed");
    wp <= 1'b0;
    rdchk(8'hAA, 8'h3F, 8'hFF, 8'h5A);
    // The counter has passed the last byte and must now point at zero.
    op(SW, 8'hAB, 2'd0, 8'h00);
    op(RNP, 8'h00, 2'd2, 8'h22);
    ahb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0, "unmapped offset not zero");
    ahb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0, "command register not zero");
    srst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk({30'h0, busy, locked}, 32'h0, "flags after second reset");
    close_out();
  end
endmodule : tb
